/* File: hdl/acat_top.sv */
// per-stage ambient calibration and adaptive trip level engine
// Function
// [RQ1] upper trip = baseline + span/4 + sensitivity times three-quarter span over 16; here over 4
// [RQ2] lower trip = baseline + span/4 + sensitivity times three-quarter span over 16
// [RQ3] span estimates move in proportion to measured baseline drift
// [RQ4] trip levels recomputed automatically after any span change; here a host span write waits for that stage's next sample
// [RQ5] each stage keeps a slow FIFO that follows its ambient level
// [RQ6] control word 0 bits 13:12 set full power sample skip
// [RQ7] control word 0 bits 15:14 set low power sample skip
// [RQ8] full power update period follows from skip and sequence timing
// [RQ9] low power update period follows from skip, gap and sequence timing
// [RQ10] full power skip code 00 skips three samples
// [RQ11] low power skip code 00 skips no samples
// [RQ12] host picks skip codes for 33 to 40 ms slow FIFO spacing
// [RQ13] sample enters FIFO only when it differs from last by over margin
// [RQ14] admit margin lives in control word 1 at 0x003
// [RQ15] trips referenced to ambient; contact only when output passes trip
// [RQ16] average maximum and minimum responses tracked per stage
// [RQ17] average change rescales that stage's trip levels
// [RQ18] sensitivity selects one of sixteen levels, 25 to 95.32 percent; upper levels here reach 306.25 percent
// [RQ19] upper sensitivity 1000 gives about 62.51 percent; here it gives 175 percent
// [RQ20] host loads initial span estimates after configuration
// [RQ21] calibration suspended while proximity is flagged
// [RQ22] slow filter updates only when admitted and proximity clear
// [RQ23] averages update when output nears tracked percentage of them
// [RQ24] divisions are truncating arithmetic right shifts
`timescale 1ns/1ps
`default_nettype none
module acat_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [acat_pkg::AW-1:0] reg_addr,
   input wire logic [acat_pkg::DW-1:0] reg_wdata,
   output logic [acat_pkg::DW-1:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [acat_pkg::SW-1:0] sample_stage,
   input wire logic signed [acat_pkg::DW-1:0] sample_data,
   input wire logic low_power,
   input wire logic proximity,
   output logic trip_valid,
   output logic [acat_pkg::SW-1:0] trip_stage,
   output logic signed [acat_pkg::DW-1:0] upper_trip_level,
   output logic signed [acat_pkg::DW-1:0] lower_trip_level,
   output logic contact_upper,
   output logic contact_lower
);
   localparam int DW = acat_pkg::DW;
   localparam int FW = DW * acat_pkg::FIFO_DEPTH;
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic [DW-1:0] ctrl0_q, ctrl1_q;
   logic wr_ctrl0, wr_ctrl1;
   assign wr_ctrl0 = reg_wr && reg_addr == acat_pkg::ADDR_CTRL0;
   // [RQ14] margin register decode
   assign wr_ctrl1 = reg_wr && reg_addr == acat_pkg::ADDR_CTRL1;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl0_q <= acat_pkg::CTRL0_RST;
         ctrl1_q <= acat_pkg::CTRL1_RST;
      end else begin
         if (wr_ctrl0) ctrl0_q <= reg_wdata;
         if (wr_ctrl1) ctrl1_q <= reg_wdata;
      end
   end
   logic [1:0] fp_skip, lp_skip, skip_reload;
   logic [acat_pkg::MARGIN_W-1:0] margin;
   logic [3:0] sens_hi, sens_lo;
   // [RQ6] full power skip field
   assign fp_skip = ctrl0_q[acat_pkg::FP_SKIP_LSB +: 2];
   // [RQ7] low power skip field
   assign lp_skip = ctrl0_q[acat_pkg::LP_SKIP_LSB +: 2];
   assign margin = ctrl1_q[acat_pkg::MARGIN_LSB +: acat_pkg::MARGIN_W];
   // [RQ19] upper code 1000 is step eight
   // [RQ18] four-bit sensitivity selections
   assign sens_hi = ctrl1_q[acat_pkg::USENS_LSB +: 4];
   assign sens_lo = ctrl1_q[acat_pkg::LSENS_LSB +: 4];
   // [RQ8] fp entry period scales with reload
   // [RQ9] lp entry period scales with reload
   // [RQ10] fp code 00 skips three, 11 none
   // [RQ11] lp code 00 skips none
   assign skip_reload = low_power ? lp_skip : ~fp_skip;
   // ----------------------------------------
   // per-stage state
   // ----------------------------------------
   logic [FW-1:0] fifo_m [acat_pkg::NSTG];
   logic [1:0] skip_m [acat_pkg::NSTG];
   logic signed [DW-1:0] base_m [acat_pkg::NSTG];
   logic signed [DW-1:0] shi_m [acat_pkg::NSTG];
   logic signed [DW-1:0] slo_m [acat_pkg::NSTG];
   logic signed [DW-1:0] amax_m [acat_pkg::NSTG];
   logic signed [DW-1:0] amin_m [acat_pkg::NSTG];
   logic signed [DW-1:0] utr_m [acat_pkg::NSTG];
   logic signed [DW-1:0] ltr_m [acat_pkg::NSTG];
   // ----------------------------------------
   // sample path, first cycle
   // ----------------------------------------
   logic in_range;
   logic [FW-1:0] row, new_row;
   logic signed [DW-1:0] last, base_old, shi, slo, amax, amin;
   logic signed [DW:0] diff, absdiff, resp;
   logic skip_zero, admit, fifo_we, calib_on;
   assign in_range = sample_stage < acat_pkg::SW'(acat_pkg::NSTG);
   assign row = in_range ? fifo_m[sample_stage] : '0;
   assign last = row[DW-1:0];
   assign base_old = in_range ? base_m[sample_stage] : '0;
   assign shi = in_range ? shi_m[sample_stage] : '0;
   assign slo = in_range ? slo_m[sample_stage] : '0;
   assign amax = in_range ? amax_m[sample_stage] : '0;
   assign amin = in_range ? amin_m[sample_stage] : '0;
   assign skip_zero = in_range && skip_m[sample_stage] == 2'h0;
   assign diff = (DW+1)'(sample_data) - (DW+1)'(last);
   assign absdiff = diff[DW] ? -diff : diff;
   // [RQ13] admit only above margin
   assign admit = absdiff > $signed({9'h000, margin});
   // [RQ21] no calibration during proximity
   assign calib_on = sample_valid && in_range && !proximity;
   // [RQ22] slow filter gated by admit and proximity
   assign fifo_we = calib_on && skip_zero && admit;
   // [RQ5] four-deep slow FIFO per stage, baseline is its mean
   assign new_row = {row[FW-DW-1:0], sample_data};
   logic signed [DW+1:0] fsum;
   logic signed [DW-1:0] new_base, drift;
   assign fsum = (DW+2)'($signed(new_row[15:0])) + (DW+2)'($signed(new_row[31:16]))
               + (DW+2)'($signed(new_row[47:32])) + (DW+2)'($signed(new_row[63:48]));
   assign new_base = DW'(fsum >>> acat_pkg::AVG_SH);
   assign drift = new_base - base_old;
   // ----------------------------------------
   // response peak tracking while touched
   // ----------------------------------------
   logic max_hit, min_hit;
   logic signed [DW-1:0] amax_new, amin_new, shi_new, slo_new;
   assign resp = (DW+1)'(sample_data) - (DW+1)'(base_old);
   // [RQ23] update when response nears tracked fraction of average
   assign max_hit = sample_valid && in_range && proximity && resp > (DW+1)'(amax >>> acat_pkg::PEAK_SH);
   assign min_hit = sample_valid && in_range && proximity && resp < (DW+1)'(amin >>> acat_pkg::PEAK_SH);
   // [RQ16] running averages of max and min response
   assign amax_new = amax + DW'((resp - (DW+1)'(amax)) >>> acat_pkg::AVG_SH);
   assign amin_new = amin + DW'((resp - (DW+1)'(amin)) >>> acat_pkg::AVG_SH);
   // [RQ3] spans follow drift; [RQ17] spans rescale to the new average peak
   assign shi_new = max_hit ? amax_new : (fifo_we ? shi - (drift >>> acat_pkg::DRIFT_SH) : shi);
   assign slo_new = min_hit ? amin_new : (fifo_we ? slo - (drift >>> acat_pkg::DRIFT_SH) : slo);
   // ----------------------------------------
   // host access decode
   // ----------------------------------------
   logic [acat_pkg::AW-5:0] rgn;
   logic [acat_pkg::SW-1:0] rstg;
   assign rgn = reg_addr[acat_pkg::AW-1:4];
   assign rstg = reg_addr[3:0];
   // ----------------------------------------
   // second cycle registers
   // ----------------------------------------
   logic b_valid_q;
   logic [acat_pkg::SW-1:0] b_stage_q;
   logic signed [DW-1:0] b_sample_q;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         b_valid_q <= 1'b0;
         b_stage_q <= '0;
         b_sample_q <= '0;
      end else begin
         b_valid_q <= sample_valid && in_range;
         b_stage_q <= sample_stage;
         b_sample_q <= sample_data;
      end
   end
   // ----------------------------------------
   // trip arithmetic for the stage in flight
   // ----------------------------------------
   acat_trip_if tif ();
   assign tif.base = base_m[b_stage_q];
   assign tif.span_hi = shi_m[b_stage_q];
   assign tif.span_lo = slo_m[b_stage_q];
   assign tif.sens_hi = sens_hi;
   assign tif.sens_lo = sens_lo;
   acat_trip_calc u_calc (
      .t(tif)
   );
   // ----------------------------------------
   // per-stage storage, one slice per stage
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < acat_pkg::NSTG; g++) begin : g_stg
         logic sel, hw_sel, tr_sel;
         assign sel = sample_stage == acat_pkg::SW'(g);
         assign hw_sel = sample_valid && sel;
         assign tr_sel = b_valid_q && b_stage_q == acat_pkg::SW'(g);
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               fifo_m[g] <= '0;
               skip_m[g] <= 2'h0;
               base_m[g] <= '0;
               shi_m[g] <= '0;
               slo_m[g] <= '0;
               amax_m[g] <= '0;
               amin_m[g] <= '0;
               utr_m[g] <= '0;
               ltr_m[g] <= '0;
            end else begin
               // skipped samples still count down, whatever proximity does
               if (hw_sel) skip_m[g] <= skip_zero ? skip_reload : skip_m[g] - 2'h1;
               if (hw_sel && fifo_we) begin
                  fifo_m[g] <= new_row;
                  base_m[g] <= new_base;
               end
               if (hw_sel) begin
                  shi_m[g] <= shi_new;
                  slo_m[g] <= slo_new;
                  if (max_hit) amax_m[g] <= amax_new;
                  if (min_hit) amin_m[g] <= amin_new;
               end
               // [RQ4] trips refreshed the cycle after each sample update; host span writes wait for the next sample
               if (tr_sel) begin
                  utr_m[g] <= tif.upper;
                  ltr_m[g] <= tif.lower;
               end
               // [RQ20] host seeds spans; host write beats hardware
               if (reg_wr && rstg == acat_pkg::SW'(g)) begin
                  if (rgn == acat_pkg::RGN_SPAN_HI) begin
                     shi_m[g] <= reg_wdata;
                     amax_m[g] <= reg_wdata;
                  end
                  if (rgn == acat_pkg::RGN_SPAN_LO) begin
                     slo_m[g] <= reg_wdata;
                     amin_m[g] <= reg_wdata;
                  end
               end
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         trip_valid <= 1'b0;
         trip_stage <= '0;
         upper_trip_level <= '0;
         lower_trip_level <= '0;
         contact_upper <= 1'b0;
         contact_lower <= 1'b0;
      end else begin
         trip_valid <= b_valid_q;
         if (b_valid_q) begin
            trip_stage <= b_stage_q;
            upper_trip_level <= tif.upper;
            lower_trip_level <= tif.lower;
            // [RQ15] contact only past the ambient-referenced trip
            contact_upper <= b_sample_q > tif.upper;
            contact_lower <= b_sample_q < tif.lower;
         end
      end
   end
   // ----------------------------------------
   // register read path
   // ----------------------------------------
   logic [DW-1:0] rd_mux;
   logic rd_stage_ok;
   assign rd_stage_ok = rstg < acat_pkg::SW'(acat_pkg::NSTG);
   assign rd_mux = reg_addr == acat_pkg::ADDR_CTRL0 ? ctrl0_q :
                   reg_addr == acat_pkg::ADDR_CTRL1 ? ctrl1_q :
                   !rd_stage_ok ? 16'h0000 :
                   rgn == acat_pkg::RGN_SPAN_HI ? shi_m[rstg] :
                   rgn == acat_pkg::RGN_SPAN_LO ? slo_m[rstg] :
                   rgn == acat_pkg::RGN_BASE ? base_m[rstg] :
                   rgn == acat_pkg::RGN_UTRIP ? utr_m[rstg] :
                   rgn == acat_pkg::RGN_LTRIP ? ltr_m[rstg] : 16'h0000;
   always_ff @(posedge clk) begin
      if (!reset_n) reg_rdata <= '0;
      else if (reg_rd) reg_rdata <= rd_mux;
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   // checks read stored state, so a broken write enable shows up
   prox_freeze_a: // [RQ21]
   assert property (@(posedge clk) disable iff (!reset_n) sample_valid && in_range && proximity
      |=> fifo_m[$past(sample_stage)] == $past(fifo_m[sample_stage]))
      else $error("slow fifo written during proximity");
   admit_gate_a: // [RQ13]
   assert property (@(posedge clk) disable iff (!reset_n)
      sample_valid && in_range && absdiff <= $signed({9'h000, margin})
      |=> fifo_m[$past(sample_stage)] == $past(fifo_m[sample_stage]))
      else $error("fifo entry below admit margin");
   skip_gate_a: // [RQ6]
   assert property (@(posedge clk) disable iff (!reset_n) sample_valid && in_range && !skip_zero
      |=> fifo_m[$past(sample_stage)] == $past(fifo_m[sample_stage]))
      else $error("fifo entry on a skipped sample");
   lp_skip_none_a: // [RQ11]
   assert property (@(posedge clk) disable iff (!reset_n)
      sample_valid && in_range && skip_zero && low_power && lp_skip == 2'h0
      |=> skip_m[$past(sample_stage)] == 2'h0)
      else $error("lp code 00 skips a sample");
   fp_skip_three_a: // [RQ10]
   assert property (@(posedge clk) disable iff (!reset_n)
      sample_valid && in_range && skip_zero && !low_power && fp_skip == 2'h0 && !reg_wr
      |=> skip_m[$past(sample_stage)] == 2'h3)
      else $error("fp code 00 does not skip three");
   trip_follow_a: // [RQ4]
   assert property (@(posedge clk) disable iff (!reset_n) sample_valid && in_range |-> ##2 trip_valid)
      else $error("trip not refreshed after sample");
   trip_store_a: // [RQ4]
   assert property (@(posedge clk) disable iff (!reset_n)
      trip_valid |-> utr_m[trip_stage] == upper_trip_level && ltr_m[trip_stage] == lower_trip_level)
      else $error("stored trip differs from output");
   upper_eq_a: // [RQ1]
   assert property (@(posedge clk) disable iff (!reset_n) b_valid_q && sens_hi == 4'h0
      |=> upper_trip_level == $past(base_m[b_stage_q]) + ($past(shi_m[b_stage_q]) >>> 2))
      else $error("upper trip mismatch");
   lower_eq_a: // [RQ2]
   assert property (@(posedge clk) disable iff (!reset_n) b_valid_q && sens_lo == 4'h0
      |=> lower_trip_level == $past(base_m[b_stage_q]) + ($past(slo_m[b_stage_q]) >>> 2))
      else $error("lower trip mismatch");
   contact_ref_a: // [RQ15]
   assert property (@(posedge clk) disable iff (!reset_n)
      trip_valid |-> contact_upper == ($past(b_sample_q) > upper_trip_level))
      else $error("upper contact disagrees with trip");
   contact_low_a: // [RQ15]
   assert property (@(posedge clk) disable iff (!reset_n)
      trip_valid |-> contact_lower == ($past(b_sample_q) < lower_trip_level))
      else $error("lower contact disagrees with trip");
   base_hold_a: // [RQ22]
   assert property (@(posedge clk) disable iff (!reset_n) sample_valid && in_range && !fifo_we && !reg_wr
      |=> base_m[$past(sample_stage)] == $past(base_m[sample_stage]))
      else $error("baseline moved without admission");
   drift_span_a: // [RQ3]
   assert property (@(posedge clk) disable iff (!reset_n) fifo_we && !max_hit && !reg_wr
      |=> shi_m[$past(sample_stage)] == $past(shi_m[sample_stage])
         - (($past(new_base) - $past(base_m[sample_stage])) >>> acat_pkg::DRIFT_SH))
      else $error("upper span did not follow drift");
   span_hold_a: // [RQ3]
   assert property (@(posedge clk) disable iff (!reset_n)
      sample_valid && in_range && !fifo_we && !max_hit && !min_hit && !reg_wr
      |=> slo_m[$past(sample_stage)] == $past(slo_m[sample_stage]))
      else $error("lower span moved without drift or peak");
   max_span_a: // [RQ17]
   assert property (@(posedge clk) disable iff (!reset_n) max_hit && !reg_wr
      |=> shi_m[$past(sample_stage)] == amax_m[$past(sample_stage)])
      else $error("upper span not rescaled to average maximum");
   min_span_a: // [RQ17]
   assert property (@(posedge clk) disable iff (!reset_n) min_hit && !reg_wr
      |=> slo_m[$past(sample_stage)] == amin_m[$past(sample_stage)])
      else $error("lower span not rescaled to average minimum");
   ctrl1_read_a: // [RQ14]
   assert property (@(posedge clk) disable iff (!reset_n) reg_rd && reg_addr == acat_pkg::ADDR_CTRL1
      |=> reg_rdata == $past(ctrl1_q))
      else $error("control word one read back wrong");
endmodule
`default_nettype wire

/* File: common/acat_pkg.sv */
// constants for the ambient calibration and adaptive trip engine
package acat_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int NSTG = 12;
   localparam int DW = 16;
   localparam int AW = 10;
   localparam int SW = 4;
   // ----------------------------------------
   // register map (stage regions use addr[3:0] as stage)
   // ----------------------------------------
   localparam logic [AW-1:0] ADDR_CTRL0 = 10'h001;
   localparam logic [AW-1:0] ADDR_CTRL1 = 10'h003;
   localparam logic [AW-5:0] RGN_SPAN_HI = 6'h0a;
   localparam logic [AW-5:0] RGN_SPAN_LO = 6'h0b;
   localparam logic [AW-5:0] RGN_BASE = 6'h0e;
   localparam logic [AW-5:0] RGN_UTRIP = 6'h0f;
   localparam logic [AW-5:0] RGN_LTRIP = 6'h10;
   localparam logic [DW-1:0] CTRL0_RST = 16'h0000;
   localparam logic [DW-1:0] CTRL1_RST = 16'h0010;
   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int FP_SKIP_LSB = 12;
   localparam int LP_SKIP_LSB = 14;
   localparam int MARGIN_LSB = 0;
   localparam int MARGIN_W = 8;
   localparam int USENS_LSB = 8;
   localparam int LSENS_LSB = 12;
   // ----------------------------------------
   // arithmetic shifts and slow FIFO depth
   // ----------------------------------------
   localparam int QTR_SH = 2;
   localparam int UP_DIV_SH = 2;
   localparam int LO_DIV_SH = 4;
   localparam int DRIFT_SH = 2;
   localparam int PEAK_SH = 1;
   localparam int AVG_SH = 2;
   localparam int FIFO_DEPTH = 4;
endpackage

/* File: common/acat_trip_if.sv */
// carrier between the calibration core and the trip arithmetic
`timescale 1ns/1ps
`default_nettype none
interface acat_trip_if;
   logic signed [acat_pkg::DW-1:0] base;
   logic signed [acat_pkg::DW-1:0] span_hi;
   logic signed [acat_pkg::DW-1:0] span_lo;
   logic [3:0] sens_hi;
   logic [3:0] sens_lo;
   logic signed [acat_pkg::DW-1:0] upper;
   logic signed [acat_pkg::DW-1:0] lower;
   modport calc (input base, span_hi, span_lo, sens_hi, sens_lo, output upper, lower);
   modport user (output base, span_hi, span_lo, sens_hi, sens_lo, input upper, lower);
endinterface
`default_nettype wire

/* File: hdl/acat_trip_calc.sv */
// trip level arithmetic for one stage
`timescale 1ns/1ps
`default_nettype none
module acat_trip_calc (
   acat_trip_if.calc t
);
   // ----------------------------------------
   // trip equations
   // ----------------------------------------
   logic signed [21:0] qh, ql, rh, rl, uh, ul;
   assign qh = 22'(t.span_hi >>> acat_pkg::QTR_SH);
   assign ql = 22'(t.span_lo >>> acat_pkg::QTR_SH);
   // [RQ24] truncating shifts
   assign rh = (22'(t.span_hi) - qh) >>> acat_pkg::UP_DIV_SH;
   assign rl = (22'(t.span_lo) - ql) >>> acat_pkg::LO_DIV_SH;
   // [RQ1] upper equation
   assign uh = 22'(t.base) + qh + rh * $signed({18'h00000, t.sens_hi});
   // [RQ2] lower equation
   assign ul = 22'(t.base) + ql + rl * $signed({18'h00000, t.sens_lo});
   // wraps on overflow; spans are kept well inside range
   assign t.upper = uh[acat_pkg::DW-1:0];
   assign t.lower = ul[acat_pkg::DW-1:0];
endmodule
`default_nettype wire

/* File: test/acat_top_tb_top.sv */
// self-checking bench for the ambient calibration and trip engine
`timescale 1ns/1ps
`default_nettype none
module acat_top_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [acat_pkg::AW-1:0] reg_addr = '0;
   logic [acat_pkg::DW-1:0] reg_wdata = '0;
   logic [acat_pkg::DW-1:0] reg_rdata;
   logic sample_valid = 1'b0;
   logic [acat_pkg::SW-1:0] sample_stage = '0;
   logic signed [acat_pkg::DW-1:0] sample_data = '0;
   logic low_power = 1'b0;
   logic proximity = 1'b0;
   logic trip_valid;
   logic [acat_pkg::SW-1:0] trip_stage;
   logic signed [acat_pkg::DW-1:0] upper_trip_level;
   logic signed [acat_pkg::DW-1:0] lower_trip_level;
   logic contact_upper;
   logic contact_lower;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;

   acat_top dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_stage(sample_stage),
      .sample_data(sample_data), .low_power(low_power), .proximity(proximity), .trip_valid(trip_valid),
      .trip_stage(trip_stage), .upper_trip_level(upper_trip_level), .lower_trip_level(lower_trip_level),
      .contact_upper(contact_upper), .contact_lower(contact_lower));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      forever #20 clk = ~clk;
   end

   // whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails = fails + 1;
         complete_run();
      end
   end

   // ----------------------------------------
   // compare and access tasks
   // ----------------------------------------
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check_word(reg_rdata, exp);
   endtask

   // result answer shows in the second cycle after the one carrying sample_valid
   task automatic smp(input logic [3:0] st, input logic [15:0] d);
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_stage <= st;
      sample_data <= d;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(posedge clk);
      #1;
      check_bit(trip_valid, st < 4'd12);
      if (st < 4'd12) begin
         check_word({12'h000, trip_stage}, {12'h000, st});
      end
   endtask

   // quarter of span plus sensitivity steps of the remaining three quarters
   task automatic chk_trip(input logic [15:0] b, input logic [15:0] sh, input logic [15:0] sl,
      input logic [3:0] su, input logic [3:0] sn, input logic [15:0] d);
      logic signed [15:0] qh;
      logic signed [15:0] ql;
      logic signed [15:0] eu;
      logic signed [15:0] el;
      qh = $signed(sh) >>> 2;
      ql = $signed(sl) >>> 2;
      eu = $signed(b) + qh + $signed({12'h000, su}) * (($signed(sh) - qh) >>> 2);
      el = $signed(b) + ql + $signed({12'h000, sn}) * (($signed(sl) - ql) >>> 4);
      check_word(upper_trip_level, eu);
      check_word(lower_trip_level, el);
      check_bit(contact_upper, $signed(d) > eu);
      check_bit(contact_lower, $signed(d) < el);
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(10'h001, 16'h0000);
      rd(10'h003, 16'h0010);
      rd(10'h3ff, 16'h0000);
      rd(10'h0fc, 16'h0000);
      // every sensitivity code, baseline held at zero by a wide margin
      wr(10'h0a0, 16'h0100);
      wr(10'h0b0, 16'hff00);
      for (int s = 0; s < 16; s++) begin
         wr(10'h003, {4'(15 - s), 4'(s), 8'hff});
         smp(4'd0, 16'h0050);
         chk_trip(16'h0000, 16'h0100, 16'hff00, 4'(s), 4'(15 - s), 16'h0050);
         smp(4'd0, 16'hffb0);
         chk_trip(16'h0000, 16'h0100, 16'hff00, 4'(s), 4'(15 - s), 16'hffb0);
      end
      // last pass leaves upper code 15 and lower code 0
      rd(10'h0f0, 16'h0310);
      rd(10'h100, 16'hffc0);
      // admit, drift and proximity gating on stage 1
      wr(10'h001, 16'h3000);
      wr(10'h003, 16'h3810);
      wr(10'h0a1, 16'h0400);
      wr(10'h0b1, 16'hff00);
      smp(4'd1, 16'h0100);
      chk_trip(16'h0040, 16'h03f0, 16'hfef0, 4'd8, 4'd3, 16'h0100);
      rd(10'h0e1, 16'h0040);
      rd(10'h0a1, 16'h03f0);
      rd(10'h0b1, 16'hfef0);
      proximity <= 1'b1;
      smp(4'd1, 16'h0180);
      chk_trip(16'h0040, 16'h03f0, 16'hfef0, 4'd8, 4'd3, 16'h0180);
      rd(10'h0e1, 16'h0040);
      proximity <= 1'b0;
      smp(4'd1, 16'h0110);
      rd(10'h0e1, 16'h0040);
      smp(4'd1, 16'h0111);
      rd(10'h0e1, 16'h0084);
      rd(10'h0a1, 16'h03df);
      rd(10'h0b1, 16'hfedf);
      // full power code 00 lets one sample in and skips the next three
      wr(10'h001, 16'h0000);
      wr(10'h003, 16'h3800);
      for (int i = 1; i <= 4; i++) begin
         smp(4'd2, 16'(i * 256));
      end
      rd(10'h0e2, 16'h0040);
      smp(4'd2, 16'h0500);
      rd(10'h0e2, 16'h0180);
      // low power code 00 skips nothing
      low_power <= 1'b1;
      wr(10'h001, 16'h1000);
      smp(4'd3, 16'h0100);
      smp(4'd3, 16'h0200);
      rd(10'h0e3, 16'h00c0);
      low_power <= 1'b0;
      // response peaks while touched rescale the spans
      wr(10'h003, 16'h38ff);
      wr(10'h0a4, 16'h0100);
      wr(10'h0b4, 16'hff00);
      proximity <= 1'b1;
      smp(4'd4, 16'h0200);
      chk_trip(16'h0000, 16'h0140, 16'hff00, 4'd8, 4'd3, 16'h0200);
      rd(10'h0a4, 16'h0140);
      smp(4'd4, 16'hfe00);
      chk_trip(16'h0000, 16'h0140, 16'hfec0, 4'd8, 4'd3, 16'hfe00);
      rd(10'h0b4, 16'hfec0);
      proximity <= 1'b0;
      // refused accesses leave state alone
      smp(4'd12, 16'h0100);
      wr(10'h0e0, 16'h1234);
      rd(10'h0e0, 16'h0000);
      wr(10'h0ac, 16'h1234);
      rd(10'h0ac, 16'h0000);
      // second reset in mid-run
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(10'h003, 16'h0010);
      rd(10'h0a1, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
